// ---- src/smr23_regs.svh ----
/*
  Holds the offsets, field positions, reset values and code points of the
  second and third mode registers.
  Assumes it is included by its bare name from the modules.
*/
`ifndef SMR23_REGS_SVH
`define SMR23_REGS_SVH

// ============================================================
// register select on the bank-select pins
`define SMR23_SEL_MODE2 3'h2
`define SMR23_SEL_MODE3 3'h3

// ============================================================
// second mode register fields
`define SMR23_M2_CWL_LO 3
`define SMR23_M2_CWL_HI 5
`define SMR23_M2_AUTO_SR 6
`define SMR23_M2_EXT_SR 7
`define SMR23_M2_WTERM_LO 9
`define SMR23_M2_WTERM_HI 10
`define SMR23_M2_RSVD_MASK 18'h27907
`define SMR23_M2_RESET 18'h00000

// ============================================================
// third mode register fields
`define SMR23_M3_MODE_LO 0
`define SMR23_M3_MODE_HI 1
`define SMR23_M3_PAT_EN 2
`define SMR23_M3_RSVD_MASK 18'h27FF8
`define SMR23_M3_RESET 18'h00000

// ============================================================
// write column latency codes and cycle counts
`define SMR23_CWL_CODE_MAX 3'h3
`define SMR23_CWL_BASE 4'h5

// predefined pattern, beat 0 in bit 0
`define SMR23_CAL_PATTERN 8'hAA
`define SMR23_BURST_BEATS 4'h8

`endif

// ---- src/smr23_pkg.sv ----
/*
  Types shared by the mode register block.
  Assumes the constants header sits beside it.
*/
package smr23_pkg;
    // write termination selection
    typedef enum logic [1:0] {
        SMR23_TERM_OFF,
        SMR23_TERM_RZQ4,
        SMR23_TERM_RZQ2,
        SMR23_TERM_RSVD
    } smr23_term_t;

    // effective termination state on the data pins
    typedef enum logic [1:0] {
        SMR23_PAD_HIZ,
        SMR23_PAD_NOMINAL,
        SMR23_PAD_WRITE
    } smr23_pad_t;

    // read burst source sequencer
    typedef enum logic [0:0] {
        SMR23_PAT_IDLE,
        SMR23_PAT_BURST
    } smr23_pat_state_t;
endpackage

// ---- src/smr23_pattern_gen.sv ----
/*
  Calibration pattern burst generator: one beat per cycle, eight beats per
  read, a new read may be taken on the last beat so bursts run back to back.
  Assumes start pulses come on the command clock and are pre-aligned to
  read latency by the caller.
*/
`include "smr23_regs.svh"

module smr23_pattern_gen (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic start,
    output logic beatValid_q,
    output logic beatBit_q
);
    smr23_pkg::smr23_pat_state_t state_q;
    logic [3:0] beat_q;
    logic lastBeat;
    logic [7:0] calPattern;

    assign lastBeat = (beat_q == (`SMR23_BURST_BEATS - 4'h1));
    assign calPattern = `SMR23_CAL_PATTERN; // beat 0 sits in bit 0

    // ============================================================
    // burst sequencer
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q <= smr23_pkg::SMR23_PAT_IDLE;
            beat_q <= 4'h0;
        end else begin
            unique case (state_q)
                smr23_pkg::SMR23_PAT_IDLE: begin
                    if (start) begin
                        state_q <= smr23_pkg::SMR23_PAT_BURST;
                        beat_q <= 4'h0;
                    end
                end
                smr23_pkg::SMR23_PAT_BURST: begin
                    if (lastBeat) begin
                        beat_q <= 4'h0; // restart keeps bursts gapless
                        if (!start) begin
                            state_q <= smr23_pkg::SMR23_PAT_IDLE;
                        end
                    end else begin
                        beat_q <= beat_q + 4'h1;
                    end
                end
            endcase
        end
    end

    // ============================================================
    // beat output, registered
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            beatValid_q <= 1'b0;
            beatBit_q <= 1'b0;
        end else begin
            beatValid_q <= (state_q == smr23_pkg::SMR23_PAT_BURST);
            beatBit_q <= calPattern[beat_q[2:0]];
        end
    end
endmodule

// ---- src/smr23_mode_regs.sv ----
/*
  Second and third mode registers of the DRAM: store on a mode-register-set
  command, decode write latency, self-refresh rate, write termination and
  the read-source redirect, and drive a pattern burst for redirected reads.
  Assumes the controller keeps its own obligations (idle banks, zero in
  reserved bits, command spacing); inputs other than the case temperature flag are on the command clock.
*/
// Notes on behaviour
// - values held until rewritten; array untouched
// - bits 5:3 set write column latency
// - write latency is column plus additive
// - bit 6 enables automatic refresh rate
// - automatic mode doubles rate when hot
// - bit 7 enables forced extended rate
// - forced extended mode always doubles rate
// - bits 10:9 select write termination
// - termination swaps to write value per burst
// - write termination only writes, never leveling
// - bit 2 clear means normal array access
// - bit 2 set with bits 1:0 zero redirects reads to pattern
// - reset still honoured while redirected
// - redirected reads answer back to back
// - pattern alternates starting zero, beat0 LSB
// - select 010 second, 011 third register
`include "smr23_regs.svh"

module smr23_mode_regs (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic modeWrite,
    input wire logic [2:0] bankSelect,
    input wire logic [17:0] modeAddr,
    input wire logic [1:0] additiveLatency,
    input wire logic readIssue,
    input wire logic writeBurstActive,
    input wire logic writeLeveling,
    input wire logic nominalTermEnable,
    input wire logic selfRefreshActive,
    input wire logic caseTempHot,
    output logic [17:0] mode2Value_q,
    output logic [17:0] mode3Value_q,
    output logic [4:0] writeLatency_q,
    output logic cwlReserved_q,
    output logic refreshRate2x_q,
    output logic [1:0] writeTermSel_q,
    output logic dynTermEnable_q,
    output logic termReserved_q,
    output smr23_pkg::smr23_pad_t padTermState_q,
    output logic patternMode_q,
    output logic readFromArray_q,
    output logic patternValid_q,
    output logic patternBit_q
);
    // synchronised temperature flag
    logic tempHot_m;
    logic tempHot_q;
    // stored fields and their decoded values
    logic [2:0] cwlCode;
    logic [1:0] termCode;
    logic [3:0] cwlCycles;
    logic [4:0] alCycles;
    logic patternStart;
    // next values of registered outputs
    logic refreshRate2x_d;
    smr23_pkg::smr23_pad_t padTermState_d;

    // latency code to cycles; codes above the supported band flagged
    function automatic logic [3:0] cwl_cycles(input logic [2:0] code);
        cwl_cycles = `SMR23_CWL_BASE + {1'b0, code};
    endfunction

    // additive code 1 is column latency minus one, 2 minus two
    function automatic logic [4:0] al_cycles(input logic [1:0] code, input logic [3:0] write_column_latency);
        unique case (code)
            2'h0: al_cycles = 5'h00;
            2'h1: al_cycles = {1'b0, write_column_latency} - 5'h01;
            2'h2: al_cycles = {1'b0, write_column_latency} - 5'h02;
            2'h3: al_cycles = 5'h00; // unused code read as none
        endcase
    endfunction

    assign cwlCode = mode2Value_q[`SMR23_M2_CWL_HI:`SMR23_M2_CWL_LO];
    assign termCode = mode2Value_q[`SMR23_M2_WTERM_HI:`SMR23_M2_WTERM_LO];
    assign cwlCycles = cwl_cycles(cwlCode);
    // additive latency counts against column latency, not read latency
    assign alCycles = al_cycles(additiveLatency, cwlCycles);

    // ============================================================
    // second register, held until the next write that selects it
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mode2Value_q <= `SMR23_M2_RESET;
        end else if (modeWrite && (bankSelect == `SMR23_SEL_MODE2)) begin
            mode2Value_q <= modeAddr;
        end
    end

    // third register; other selects fall through untouched
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mode3Value_q <= `SMR23_M3_RESET;
        end else if (modeWrite && (bankSelect == `SMR23_SEL_MODE3)) begin
            mode3Value_q <= modeAddr;
        end
    end

    // ============================================================
    // temperature flag from a sensor outside this clock, two stages
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            tempHot_m <= 1'b0;
            tempHot_q <= 1'b0;
        end else begin
            tempHot_m <= caseTempHot;
            tempHot_q <= tempHot_m;
        end
    end

    // ============================================================
    // write latency decode
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            writeLatency_q <= 5'h05;
            cwlReserved_q <= 1'b0;
        end else begin
            // additive latency counts against column latency, not read latency
            writeLatency_q <= {1'b0, cwlCycles} + alCycles;
            cwlReserved_q <= (cwlCode > `SMR23_CWL_CODE_MAX);
        end
    end

    // ============================================================
    // self-refresh rate: forced extended wins, else automatic when hot
    always_comb begin
        if (mode2Value_q[`SMR23_M2_EXT_SR]) begin
            refreshRate2x_d = 1'b1;
        end else if (mode2Value_q[`SMR23_M2_AUTO_SR]) begin
            refreshRate2x_d = tempHot_q;
        end else begin
            refreshRate2x_d = 1'b0;
        end
    end

    // rate held in a flop so the pin never glitches between modes
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            refreshRate2x_q <= 1'b0;
        end else begin
            refreshRate2x_q <= refreshRate2x_d;
        end
    end

    // ============================================================
    // write termination decode and pad state
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            writeTermSel_q <= 2'h0;
            dynTermEnable_q <= 1'b0;
            termReserved_q <= 1'b0;
        end else begin
            writeTermSel_q <= termCode;
            dynTermEnable_q <= (termCode != smr23_pkg::SMR23_TERM_OFF);
            termReserved_q <= (termCode == smr23_pkg::SMR23_TERM_RSVD);
        end
    end

    // leveling blocks the write value; nominal termination off during self-refresh
    always_comb begin
        if (dynTermEnable_q && writeBurstActive && !writeLeveling) begin
            padTermState_d = smr23_pkg::SMR23_PAD_WRITE;
        end else if (nominalTermEnable && !selfRefreshActive) begin
            padTermState_d = smr23_pkg::SMR23_PAD_NOMINAL;
        end else begin
            padTermState_d = smr23_pkg::SMR23_PAD_HIZ;
        end
    end

    // pad state registered; costs one cycle of lag behind the burst pins
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            padTermState_q <= smr23_pkg::SMR23_PAD_HIZ;
        end else begin
            padTermState_q <= padTermState_d;
        end
    end

    // ============================================================
    // read source select; mode bits ignored while redirect is off
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            patternMode_q <= 1'b0;
            readFromArray_q <= 1'b1;
        end else begin
            patternMode_q <= mode3Value_q[`SMR23_M3_PAT_EN]
                && (mode3Value_q[`SMR23_M3_MODE_HI:`SMR23_M3_MODE_LO] == 2'h0);
            readFromArray_q <= !mode3Value_q[`SMR23_M3_PAT_EN];
        end
    end

    // only reads seen while the redirect is live start a burst
    assign patternStart = readIssue && patternMode_q;

    // redirected reads start a pattern burst; array access suppressed
    smr23_pattern_gen u_pattern (
        .clk(clk),
        .reset_n(reset_n),
        .start(patternStart),
        .beatValid_q(patternValid_q),
        .beatBit_q(patternBit_q)
    );
endmodule

// ---- testbench/smr23_mode_regs_monitor.sv ----
/*
  Checker on the mode register block ports.
  Assumes a bind from the bench top; one clock, sync active-low reset.
*/
module smr23_mode_regs_monitor (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic modeWrite,
    input wire logic [2:0] bankSelect,
    input wire logic [17:0] modeAddr,
    input wire logic readIssue,
    input wire logic writeBurstActive,
    input wire logic writeLeveling,
    input wire logic [17:0] mode2Value_q,
    input wire logic [17:0] mode3Value_q,
    input wire logic refreshRate2x_q,
    input wire logic dynTermEnable_q,
    input smr23_pkg::smr23_pad_t padTermState_q,
    input wire logic patternMode_q,
    input wire logic readFromArray_q,
    input wire logic patternValid_q,
    input wire logic patternBit_q
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========
    // decoded outputs lag the stored value one cycle, hence the $past guards
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_store;
        modeWrite && bankSelect == 3'h2 |=> mode2Value_q == $past(modeAddr); endproperty
    a_store: assert property (p_store) else $error("second register not stored");
    property p_hold;
        !(modeWrite && bankSelect == 3'h3) |=> $stable(mode3Value_q); endproperty
    a_hold: assert property (p_hold) else $error("third register changed unasked");
    property p_rate;
        $past(reset_n) && $past(mode2Value_q[7]) |-> refreshRate2x_q; endproperty
    a_rate: assert property (p_rate) else $error("forced rate not doubled");
    property p_rate1x;
        $past(reset_n) && $past(mode2Value_q[7:6]) == 2'h0 |-> !refreshRate2x_q; endproperty
    a_rate1x: assert property (p_rate1x) else $error("rate doubled while off");
    property p_term;
        $past(reset_n) |-> dynTermEnable_q == ($past(mode2Value_q[10:9]) != 2'h0); endproperty
    a_term: assert property (p_term) else $error("dynamic term enable wrong");
    property p_pad;
        $past(dynTermEnable_q && writeBurstActive && !writeLeveling)
        |-> padTermState_q == smr23_pkg::SMR23_PAD_WRITE; endproperty
    a_pad: assert property (p_pad) else $error("write term not applied");
    property p_lvl;
        $past(writeLeveling) |-> padTermState_q != smr23_pkg::SMR23_PAD_WRITE; endproperty
    a_lvl: assert property (p_lvl) else $error("write term during leveling");
    property p_pat;
        readIssue && patternMode_q && !patternValid_q && !$past(readIssue)
        |=> ##1 (patternValid_q && !patternBit_q) ##1 (patternValid_q && patternBit_q); endproperty
    a_pat: assert property (p_pat) else $error("pattern burst start wrong");
    property p_rst;
        $rose(reset_n) |-> mode3Value_q == 18'h00000 && readFromArray_q && !patternValid_q;
    endproperty
    a_rst: assert property (p_rst) else $error("reset not honoured");
    c_pat: cover property (readIssue && patternMode_q);
    c_b2b: cover property (readIssue && patternValid_q);
    c_wr: cover property (padTermState_q == smr23_pkg::SMR23_PAD_WRITE);
endmodule

// ---- testbench/smr23_ctrl_model.sv ----
/*
  Controller model: mode writes and reads on the command clock.
  Assumes callers enter its tasks just after a rising edge.
*/
`include "smr23_regs.svh"
module smr23_ctrl_model (
    output logic modeWrite,
    output logic [2:0] bankSelect,
    output logic [17:0] modeAddr,
    output logic readIssue,
    input wire logic clk
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========
    // never activates a bank, so all banks stay precharged
    initial begin
        modeWrite = 1'b0;
        readIssue = 1'b0;
        bankSelect = 3'h0;
        modeAddr = 18'h00000;
    end
    // released pins flip so a stale value cannot pass for a new one
    task automatic mrs(input logic [2:0] sel, input logic [17:0] v);
        logic [17:0] w;
        w = v & ~(sel == 3'h3 ? `SMR23_M3_RSVD_MASK : `SMR23_M2_RSVD_MASK);
        if (sel == 3'h2 && v[7]) w[6] = 1'b0;
        @(posedge clk);
        #1;
        modeWrite = 1'b1;
        bankSelect = sel;
        modeAddr = w;
        @(posedge clk);
        #1;
        modeWrite = 1'b0;
        bankSelect = ~bankSelect;
        modeAddr = ~modeAddr;
        repeat (4) @(posedge clk);
        #1;
    endtask
    // reads eight cycles apart keep bursts gapless
    task automatic rd(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            #1;
            readIssue = 1'b1;
            @(posedge clk);
            #1;
            readIssue = 1'b0;
            repeat (6) @(posedge clk);
        end
        #1;
    endtask
endmodule

// ---- testbench/smr23_mode_regs_tb.sv ----
/*
  Bench for the mode register block: random second-register writes, pattern reads.
  Assumes the checker and the controller model are compiled before it.
*/
module smr23_mode_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, reset_n, mw, ri, wb, wlv, nom, sr, hot, cr, r2, dt, tr, pm, fa, pv, pb;
    logic [2:0] bs;
    logic [17:0] ma, m2, m3;
    logic [1:0] al, tsel;
    logic [4:0] wl;
    smr23_pkg::smr23_pad_t pad;
    int bad_count = 0;
    int checked = 0;
    smr23_ctrl_model m (.clk(clk), .modeWrite(mw), .bankSelect(bs), .modeAddr(ma),
        .readIssue(ri));
    smr23_mode_regs dut_u (.clk(clk), .reset_n(reset_n), .modeWrite(mw), .bankSelect(bs),
        .modeAddr(ma), .additiveLatency(al), .readIssue(ri), .writeBurstActive(wb),
        .writeLeveling(wlv), .nominalTermEnable(nom), .selfRefreshActive(sr),
        .caseTempHot(hot), .mode2Value_q(m2), .mode3Value_q(m3), .writeLatency_q(wl),
        .cwlReserved_q(cr), .refreshRate2x_q(r2), .writeTermSel_q(tsel),
        .dynTermEnable_q(dt), .termReserved_q(tr), .padTermState_q(pad),
        .patternMode_q(pm), .readFromArray_q(fa), .patternValid_q(pv), .patternBit_q(pb));
    // ==========
    // 50 MHz command clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    function automatic logic [4:0] exp_wl(input logic [2:0] c, input logic [1:0] a);
        logic [4:0] cw;
        cw = 5'h05 + {2'h0, c};
        return cw + (a == 2'h1 ? cw - 5'h01 : (a == 2'h2 ? cw - 5'h02 : 5'h00));
    endfunction
    // write value wins over nominal; self-refresh drops nominal to high impedance
    function automatic logic [1:0] exp_pad(input logic d);
        if (d && wb && !wlv) return 2'h2;
        return (nom && !sr) ? 2'h1 : 2'h0;
    endfunction
    task automatic chk(input logic [17:0] g, input logic [17:0] e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic report_and_stop();
        $display("counts: checked=%0d bad=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic capture();
        int k;
        k = 0;
        while (pv !== 1'b1 && k < 12) begin
            @(posedge clk);
            #1;
            k++;
        end
        if (pv !== 1'b1) begin
            bad_count++;
            report_and_stop();
        end
        for (int i = 0; i < 16; i++) begin
            chk(18'({pv, pb}), 18'({1'b1, i[0]}));
            @(posedge clk);
            #1;
        end
        chk(18'(pv), 18'h00000);
    endtask
    initial begin
        logic [2:0] code;
        logic [1:0] ts;
        logic [1:0] rf;
        logic [17:0] v;
        reset_n = 1'b0;
        al = 2'h0;
        {wb, wlv, nom, sr, hot} = 5'h00;
        void'($urandom(32'h6A3A1B39));
        repeat (8) @(posedge clk);
        #1;
        reset_n = 1'b1;
        @(posedge clk);
        #1;
        chk(18'({wl, fa, pad}), 18'h0002C);
        chk(m2 | m3, 18'h00000);
        $display("test reset done");
        for (int i = 0; i < 12; i++) begin
            {al, code, rf, ts} = 9'($urandom);
            if (i == 0) {al, code} = 5'h0F;
            if (rf == 2'h3) rf = 2'h0;
            {wb, wlv, nom, sr, hot} = 5'($urandom);
            if (hot && rf == 2'h0) rf = 2'h2;
            v = {7'h00, ts, 1'b0, rf, code, 3'h0};
            m.mrs(3'h2, v);
            m.mrs(i[0] ? 3'h1 : 3'h6, ~v);
            chk(m2, v);
            chk(18'(wl), 18'(exp_wl(code, al)));
            chk(18'(cr), 18'(code > 3'h3));
            chk(18'(r2), 18'(rf[1] | (rf[0] & hot)));
            chk(18'({tr, dt, tsel}), 18'({ts == 2'h3, ts != 2'h0, ts}));
            chk(18'(pad), 18'(exp_pad(ts != 2'h0)));
        end
        $display("test writes done");
        m.mrs(3'h3, 18'h00004);
        chk(18'({pm, fa}), 18'h00002);
        fork
            m.rd(2);
            capture();
        join
        reset_n = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        reset_n = 1'b1;
        @(posedge clk);
        #1;
        chk(18'({m3[16:0], fa}), 18'h00001);
        m.mrs(3'h3, 18'h00007);
        chk(18'({pm, fa}), 18'h00000);
        m.mrs(3'h3, 18'h00003);
        chk(18'({pm, fa}), 18'h00001);
        fork
            m.rd(1);
            repeat (9) begin
                @(posedge clk);
                #1;
                chk(18'(pv), 18'h00000);
            end
        join
        $display("test pattern done");
        report_and_stop();
    end
endmodule
bind smr23_mode_regs smr23_mode_regs_monitor mon_u (.clk(clk), .reset_n(reset_n),
    .modeWrite(modeWrite), .bankSelect(bankSelect), .modeAddr(modeAddr),
    .readIssue(readIssue), .writeBurstActive(writeBurstActive),
    .writeLeveling(writeLeveling), .mode2Value_q(mode2Value_q),
    .mode3Value_q(mode3Value_q), .refreshRate2x_q(refreshRate2x_q),
    .dynTermEnable_q(dynTermEnable_q), .padTermState_q(padTermState_q),
    .patternMode_q(patternMode_q), .readFromArray_q(readFromArray_q),
    .patternValid_q(patternValid_q), .patternBit_q(patternBit_q));
